// ==== bench/hsm_host_model.sv ====
// Host processor model: AHB-Lite master issuing single word transfers
module hsm_host_model (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // One word transfer; waits are bounded, the bench watchdog ends a hang
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1 && n < 100)
    begin
      n++;
      @(posedge clk);
    end
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1 && n < 200)
    begin
      n++;
      @(posedge clk);
    end
    rd = hrdata;
    // Released data lines show a changed pattern
    hwdata <= ~wd;
  endtask : xfer
endmodule : hsm_host_model

// ==== bench/tb_hsm_regs.sv ====
// Self-checking bench for the host status, window and parity registers
module tb_hsm_regs;
  import hsm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk;
  logic rst;
  logic hsel, hwrite, hready, hreadyout, hresp, memRdDone, memBankSel, extIrq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] ev [0:4];
  logic [15:0] en [0:4];
  logic [3:0]  memRdParity, memAddrUpper, expUp;
  int          failCount = 0;
  int          checks = 0;

  assign hready = hreadyout;

  hsm_host_model hsm_host_model_i (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  hsm_regs hsm_regs_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .backplaneEvents(ev[0]), .backplaneEnables(en[0]), .segmenterEvents(ev[1]), .segmenterEnables(en[1]),
    .reassemblerEvents(ev[2]), .reassemblerEnables(en[2]), .cellPortEvents(ev[3]), .cellPortEnables(en[3]),
    .clockRecEvents(ev[4]), .clockRecEnables(en[4]), .memRdDone(memRdDone), .memRdParity(memRdParity),
    .memAddrUpper(memAddrUpper), .memBankSel(memBankSel), .extIrq(extIrq));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      failCount++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wrReg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] unused;
    hsm_host_model_i.xfer(1'b1, a, d, unused);
  endtask : wrReg

  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    hsm_host_model_i.xfer(1'b0, a, 32'h0, d);
    check(d, exp, what);
  endtask : rdChk

  task conclude;
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (20000) @(posedge clk);
    failCount++;
    $display("wrong value at %0t: watchdog expired", $time);
    conclude();
  end

  initial
  begin
    rst = 1'b1;
    memRdDone = 1'b0;
    memRdParity = 4'h0;
    for (int k = 0; k < 5; k++)
    begin
      ev[k] = 16'h0;
      en[k] = 16'h0;
    end
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdChk(ADDR_MAIN_CONTROL, 32'h0, "control reset");
    rdChk(ADDR_SERVICE_STATUS, 32'h0, "status idle");
    rdChk(ADDR_MEM_WINDOW, 32'h0, "window reset");
    rdChk(ADDR_READ_PARITY, 32'h0, "parity reset");
    rdChk(12'hFFC, 32'h0, "unmapped");
    $display("test reset done");
    for (int k = 0; k < 5; k++)
    begin
      ev[k] <= 16'h0100 << k;
      en[k] <= 16'h0001;
      rdChk(ADDR_SERVICE_STATUS, 32'h0, "unmatched event");
      en[k] <= 16'h0100 << k;
      rdChk(ADDR_SERVICE_STATUS, 32'h80 | (32'h1 << k), "request");
      wrReg(ADDR_MAIN_CONTROL, 32'h1 << k);
      rdChk(ADDR_MAIN_CONTROL, 32'h1 << k, "control");
      repeat (2) @(posedge clk);
      check({31'h0, extIrq}, 32'h1, "irq on");
      wrReg(ADDR_MAIN_CONTROL, 32'h1F ^ (32'h1 << k));
      repeat (2) @(posedge clk);
      check({31'h0, extIrq}, 32'h0, "irq disabled");
      ev[k] <= 16'h0;
      rdChk(ADDR_SERVICE_STATUS, 32'h0, "request cleared");
    end
    wrReg(ADDR_SERVICE_STATUS, 32'hFFFF);
    rdChk(ADDR_SERVICE_STATUS, 32'h0, "status read-only");
    check({31'h0, hresp}, 32'h0, "okay response");
    rdChk(ADDR_EVENT_STATUS, 32'h1F, "sticky events");
    wrReg(ADDR_EVENT_MASK, 32'h1);
    rdChk(ADDR_EVENT_MASK, 32'h1, "event mask");
    repeat (2) @(posedge clk);
    check({31'h0, extIrq}, 32'h1, "masked event irq");
    wrReg(ADDR_EVENT_STATUS, 32'h1);
    rdChk(ADDR_EVENT_STATUS, 32'h1E, "event cleared");
    repeat (2) @(posedge clk);
    check({31'h0, extIrq}, 32'h0, "event irq cleared");
    $display("test requests done");
    wrReg(ADDR_MEM_WINDOW, 32'h15);
    rdChk(ADDR_MEM_WINDOW, 32'h15, "window");
    for (int m = 0; m < 4; m++)
    begin
      wrReg(ADDR_MEM_CONFIG, m);
      repeat (2) @(posedge clk);
      expUp = 4'h0;
      for (int j = 0; j <= m; j++)
        expUp[j] = (5'h15 >> j) & 1'b1;
      check({28'h0, memAddrUpper}, {28'h0, expUp}, "upper address");
      check({31'h0, memBankSel}, (32'h15 >> (m + 1)) & 32'h1, "bank select");
    end
    $display("test window done");
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      memRdDone <= 1'b1;
      memRdParity <= i ? 4'h5 : 4'hA;
      @(posedge clk);
      memRdDone <= 1'b0;
      memRdParity <= 4'hF;
      rdChk(ADDR_READ_PARITY, i ? 32'h5 : 32'hA, "parity");
    end
    wrReg(ADDR_READ_PARITY, 32'hFFFF);
    rdChk(ADDR_READ_PARITY, 32'h5, "parity read-only");
    $display("test parity done");
    conclude();
  end
endmodule : tb_hsm_regs

// ==== inc/hsm_pkg.sv ====
// Constants for the host status, memory window and parity registers
package hsm_pkg;

  localparam int          DATA_W     = 32;
  localparam int          DEC_W      = 12;
  localparam int          REG_W      = 16;
  localparam int          EVT_W      = 16;
  localparam int          NUM_MOD    = 5;
  localparam int          WIN_W      = 5;
  localparam int          PAR_W      = 4;
  localparam int          MODE_W     = 2;
  localparam int          UPPER_W    = 4;
  localparam int          ADDR_SHIFT = 2;

  // Register indices; byte address is four times the index
  localparam logic [DEC_W-1:0] IDX_MAIN_CONTROL   = 12'h000;
  localparam logic [DEC_W-1:0] IDX_SERVICE_STATUS = 12'h002;
  localparam logic [DEC_W-1:0] IDX_MEM_WINDOW     = 12'h030;
  localparam logic [DEC_W-1:0] IDX_READ_PARITY    = 12'h036;
  localparam logic [DEC_W-1:0] IDX_MEM_CONFIG     = 12'h040;
  localparam logic [DEC_W-1:0] IDX_EVENT_STATUS   = 12'h050;
  localparam logic [DEC_W-1:0] IDX_EVENT_MASK     = 12'h052;

  localparam logic [DEC_W-1:0] ADDR_MAIN_CONTROL   = IDX_MAIN_CONTROL << ADDR_SHIFT;
  localparam logic [DEC_W-1:0] ADDR_SERVICE_STATUS = IDX_SERVICE_STATUS << ADDR_SHIFT;
  localparam logic [DEC_W-1:0] ADDR_MEM_WINDOW     = IDX_MEM_WINDOW << ADDR_SHIFT;
  localparam logic [DEC_W-1:0] ADDR_READ_PARITY    = IDX_READ_PARITY << ADDR_SHIFT;
  localparam logic [DEC_W-1:0] ADDR_MEM_CONFIG     = IDX_MEM_CONFIG << ADDR_SHIFT;
  localparam logic [DEC_W-1:0] ADDR_EVENT_STATUS   = IDX_EVENT_STATUS << ADDR_SHIFT;
  localparam logic [DEC_W-1:0] ADDR_EVENT_MASK     = IDX_EVENT_MASK << ADDR_SHIFT;

  // Field positions
  localparam int SERVICE_BIT   = 7;
  localparam int MOD_BACKPLANE = 0;
  localparam int MOD_SEGMENTER = 1;
  localparam int MOD_REASSEMB  = 2;
  localparam int MOD_CELL_PORT = 3;
  localparam int MOD_CLOCK_REC = 4;

  // Reset values
  localparam logic [REG_W-1:0]   MAIN_CONTROL_RST = 16'h0000;
  localparam logic [WIN_W-1:0]   WINDOW_RST       = 5'h00;
  localparam logic [PAR_W-1:0]   PARITY_RST       = 4'h0;
  localparam logic [MODE_W-1:0]  MEM_CONFIG_RST   = 2'h0;
  localparam logic [NUM_MOD-1:0] EVENT_RST        = 5'h00;

  // External memory size codes
  localparam logic [MODE_W-1:0] MODE_32K  = 2'h0;
  localparam logic [MODE_W-1:0] MODE_64K  = 2'h1;
  localparam logic [MODE_W-1:0] MODE_128K = 2'h2;
  localparam logic [MODE_W-1:0] MODE_256K = 2'h3;

  localparam int       HTRANS_ACTIVE_BIT = 1;
  localparam logic     HRESP_OKAY        = 1'b0;

endpackage : hsm_pkg

// ==== src/hsm_regs.sv ====
// Host status, memory window and read parity registers behind an AHB-Lite slave
// Operation
// - Status bit 0: backplane event and enable
// - Status bit 1: segmenter event and enable
// - Status bit 2: reassembler event and enable
// - Status bit 3: cell port event and enable
// - Status bit 4: clock recovery event and enable
// - Interrupt when request and its enable set
// - Control bits 4:0 enable module interrupts
// - Status bit 7 is OR of requests
// - Status bits 6:5 reserved, status read-only
// - Status upper byte always reads zero
// - Window bit 0 drives memory line 14
// - Window bits 1-4 address or bank select
// - Size field picks 15 to 18 lines
// - Window applied to every memory access automatically
// - Capture odd word parity into bits 1:0
// - Capture even word parity into bits 3:2
// - Parity register read-only, upper bits zero
module hsm_regs (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [hsm_pkg::DATA_W-1:0]     hwdata,
  input  wire logic                           hready,
  output logic      [hsm_pkg::DATA_W-1:0]     hrdata,
  output logic                                hreadyout,
  output logic                                hresp,
  input  wire logic [hsm_pkg::EVT_W-1:0]      backplaneEvents,
  input  wire logic [hsm_pkg::EVT_W-1:0]      backplaneEnables,
  input  wire logic [hsm_pkg::EVT_W-1:0]      segmenterEvents,
  input  wire logic [hsm_pkg::EVT_W-1:0]      segmenterEnables,
  input  wire logic [hsm_pkg::EVT_W-1:0]      reassemblerEvents,
  input  wire logic [hsm_pkg::EVT_W-1:0]      reassemblerEnables,
  input  wire logic [hsm_pkg::EVT_W-1:0]      cellPortEvents,
  input  wire logic [hsm_pkg::EVT_W-1:0]      cellPortEnables,
  input  wire logic [hsm_pkg::EVT_W-1:0]      clockRecEvents,
  input  wire logic [hsm_pkg::EVT_W-1:0]      clockRecEnables,
  input  wire logic                           memRdDone,
  input  wire logic [hsm_pkg::PAR_W-1:0]      memRdParity,
  output logic      [hsm_pkg::UPPER_W-1:0]    memAddrUpper,
  output logic                                memBankSel,
  output logic                                extIrq
);
  import hsm_pkg::*;

  logic [NUM_MOD-1:0]  modReq;
  logic                accept;
  logic                wrEn;

  logic                dphValid_reg;
  logic                dphValid_next;
  logic                dphWrite_reg;
  logic                dphWrite_next;
  logic [DEC_W-1:0]    dphAddr_reg;
  logic [DEC_W-1:0]    dphAddr_next;
  logic [DATA_W-1:0]   hrdata_reg;
  logic [DATA_W-1:0]   hrdata_next;
  logic                hreadyout_reg;

  logic [REG_W-1:0]    mainControl_reg;
  logic [REG_W-1:0]    mainControl_next;
  logic [WIN_W-1:0]    window_reg;
  logic [WIN_W-1:0]    window_next;
  logic [MODE_W-1:0]   memSize_reg;
  logic [MODE_W-1:0]   memSize_next;
  logic [PAR_W-1:0]    parity_reg;
  logic [PAR_W-1:0]    parity_next;
  logic [NUM_MOD-1:0]  evtStatus_reg;
  logic [NUM_MOD-1:0]  evtStatus_next;
  logic [NUM_MOD-1:0]  evtMask_reg;
  logic [NUM_MOD-1:0]  evtMask_next;
  logic [NUM_MOD-1:0]  reqPrev_reg;

  logic [UPPER_W-1:0]  memAddrUpper_reg;
  logic [UPPER_W-1:0]  memAddrUpper_next;
  logic                memBankSel_reg;
  logic                memBankSel_next;
  logic                extIrq_reg;
  logic                extIrq_next;

  hsm_req_reduce #(.W(EVT_W)) uBackplane (
    .events  (backplaneEvents),
    .enables (backplaneEnables),
    .request (modReq[MOD_BACKPLANE])
  );
  hsm_req_reduce #(.W(EVT_W)) uSegmenter (
    .events  (segmenterEvents),
    .enables (segmenterEnables),
    .request (modReq[MOD_SEGMENTER])
  );
  hsm_req_reduce #(.W(EVT_W)) uReassembler (
    .events  (reassemblerEvents),
    .enables (reassemblerEnables),
    .request (modReq[MOD_REASSEMB])
  );
  hsm_req_reduce #(.W(EVT_W)) uCellPort (
    .events  (cellPortEvents),
    .enables (cellPortEnables),
    .request (modReq[MOD_CELL_PORT])
  );
  hsm_req_reduce #(.W(EVT_W)) uClockRec (
    .events  (clockRecEvents),
    .enables (clockRecEnables),
    .request (modReq[MOD_CLOCK_REC])
  );

  assign accept = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;
  assign wrEn   = dphValid_reg & dphWrite_reg;

  // Register file next values; writes land at the end of the data phase
  always_comb
  begin
    mainControl_next = mainControl_reg;
    window_next      = window_reg;
    memSize_next     = memSize_reg;
    evtMask_next     = evtMask_reg;
    evtStatus_next   = evtStatus_reg;
    parity_next      = parity_reg;
    if (wrEn)
    begin
      unique case (dphAddr_reg)
        ADDR_MAIN_CONTROL: mainControl_next = hwdata[REG_W-1:0];
        ADDR_MEM_WINDOW:   window_next = hwdata[WIN_W-1:0];
        ADDR_MEM_CONFIG:   memSize_next = hwdata[MODE_W-1:0];
        ADDR_EVENT_MASK:   evtMask_next = hwdata[NUM_MOD-1:0];
        ADDR_EVENT_STATUS: evtStatus_next = evtStatus_reg & ~hwdata[NUM_MOD-1:0];
        default:           mainControl_next = mainControl_reg;
      endcase
    end
    // New request edges win over a clearing write
    evtStatus_next = evtStatus_next | (modReq & ~reqPrev_reg);
    if (memRdDone)
    begin
      parity_next = memRdParity;
    end
  end

  // Read mux works on next values so a read right after a write sees it
  function automatic logic [DATA_W-1:0] readWord(input logic [DEC_W-1:0] a);
    logic [DATA_W-1:0] w;
    w = '0;
    unique case (a)
      ADDR_MAIN_CONTROL:   w[REG_W-1:0] = mainControl_next;
      ADDR_SERVICE_STATUS:
      begin
        w[NUM_MOD-1:0] = modReq;
        w[SERVICE_BIT] = |modReq;
      end
      ADDR_MEM_WINDOW:     w[WIN_W-1:0] = window_next;
      ADDR_READ_PARITY:    w[PAR_W-1:0] = parity_next;
      ADDR_MEM_CONFIG:     w[MODE_W-1:0] = memSize_next;
      ADDR_EVENT_STATUS:   w[NUM_MOD-1:0] = evtStatus_next;
      ADDR_EVENT_MASK:     w[NUM_MOD-1:0] = evtMask_next;
      default:             w = '0;
    endcase
    return w;
  endfunction : readWord

  // Bus slave: zero wait states, always OKAY
  always_comb
  begin
    dphValid_next = accept;
    dphWrite_next = accept & hwrite;
    dphAddr_next  = accept ? haddr[DEC_W-1:0] : dphAddr_reg;
    hrdata_next   = (accept & ~hwrite) ? readWord(haddr[DEC_W-1:0]) : '0;
  end

  // Memory upper address and bank select from window and size; interrupt from enabled requests and masked events
  always_comb
  begin
    for (int k = 0; k < UPPER_W; k++)
    begin
      memAddrUpper_next[k] = (3'(k) <= {1'b0, memSize_reg}) ? window_reg[k] : 1'b0;
    end
    memBankSel_next = window_reg[{1'b0, memSize_reg} + 3'h1];
    extIrq_next     = (|(modReq & mainControl_reg[NUM_MOD-1:0])) | (|(evtStatus_reg & evtMask_reg));
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dphValid_reg     <= 1'b0;
      dphWrite_reg     <= 1'b0;
      dphAddr_reg      <= '0;
      hrdata_reg       <= '0;
      hreadyout_reg    <= 1'b1;
      mainControl_reg  <= MAIN_CONTROL_RST;
      window_reg       <= WINDOW_RST;
      memSize_reg      <= MEM_CONFIG_RST;
      parity_reg       <= PARITY_RST;
      evtStatus_reg    <= EVENT_RST;
      evtMask_reg      <= EVENT_RST;
      reqPrev_reg      <= EVENT_RST;
      memAddrUpper_reg <= '0;
      memBankSel_reg   <= 1'b0;
      extIrq_reg       <= 1'b0;
    end
    else
    begin
      dphValid_reg     <= dphValid_next;
      dphWrite_reg     <= dphWrite_next;
      dphAddr_reg      <= dphAddr_next;
      hrdata_reg       <= hrdata_next;
      hreadyout_reg    <= 1'b1;
      mainControl_reg  <= mainControl_next;
      window_reg       <= window_next;
      memSize_reg      <= memSize_next;
      parity_reg       <= parity_next;
      evtStatus_reg    <= evtStatus_next;
      evtMask_reg      <= evtMask_next;
      reqPrev_reg      <= modReq;
      memAddrUpper_reg <= memAddrUpper_next;
      memBankSel_reg   <= memBankSel_next;
      extIrq_reg       <= extIrq_next;
    end
  end

  assign hrdata       = hrdata_reg;
  assign hreadyout    = hreadyout_reg;
  assign hresp        = HRESP_OKAY;
  assign memAddrUpper = memAddrUpper_reg;
  assign memBankSel   = memBankSel_reg;
  assign extIrq       = extIrq_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic rdStatus;
  logic rdParity;
  assign rdStatus = accept & ~hwrite & (haddr[DEC_W-1:0] == ADDR_SERVICE_STATUS);
  assign rdParity = accept & ~hwrite & (haddr[DEC_W-1:0] == ADDR_READ_PARITY);

  backplaneBit_a : assert property (
    rdStatus |=> hrdata[MOD_BACKPLANE] == $past(|(backplaneEvents & backplaneEnables)))
    else $error("status bit 0 wrong");
  segmenterBit_a : assert property (
    rdStatus |=> hrdata[MOD_SEGMENTER] == $past(|(segmenterEvents & segmenterEnables)))
    else $error("status bit 1 wrong");
  reassemblerBit_a : assert property (
    rdStatus |=> hrdata[MOD_REASSEMB] == $past(|(reassemblerEvents & reassemblerEnables)))
    else $error("status bit 2 wrong");
  cellPortBit_a : assert property (
    rdStatus |=> hrdata[MOD_CELL_PORT] == $past(|(cellPortEvents & cellPortEnables)))
    else $error("status bit 3 wrong");
  clockRecBit_a : assert property (
    rdStatus |=> hrdata[MOD_CLOCK_REC] == $past(|(clockRecEvents & clockRecEnables)))
    else $error("status bit 4 wrong");
  hwIrq_a : assert property (
    (|(modReq & mainControl_reg[NUM_MOD-1:0])) |=> extIrq)
    else $error("interrupt missing for enabled request");
  ctrlWrite_a : assert property (
    wrEn && dphAddr_reg == ADDR_MAIN_CONTROL |=> mainControl_reg[NUM_MOD-1:0] == $past(hwdata[NUM_MOD-1:0]))
    else $error("control enables not written");
  serviceBit_a : assert property (
    rdStatus |=> hrdata[SERVICE_BIT] == $past(|modReq))
    else $error("service summary bit wrong");
  statusZero_a : assert property (
    rdStatus |=> hrdata[DATA_W-1:SERVICE_BIT+1] == '0 && hrdata[SERVICE_BIT-1:NUM_MOD] == '0)
    else $error("status reserved bits not zero");
  windowLine_a : assert property (
    ##1 memAddrUpper[0] == $past(window_reg[0]))
    else $error("window bit 0 not on line 14");
  fullMode_a : assert property (
    memSize_reg == MODE_256K |=> memAddrUpper == $past(window_reg[UPPER_W-1:0]) && memBankSel == $past(window_reg[UPPER_W]))
    else $error("256K mapping wrong");
  smallMode_a : assert property (
    memSize_reg == MODE_32K |=> memAddrUpper[UPPER_W-1:1] == '0 && memBankSel == $past(window_reg[1]))
    else $error("32K mapping wrong");
  parityCap_a : assert property (
    memRdDone |=> parity_reg == $past(memRdParity))
    else $error("parity not captured");
  parityRead_a : assert property (
    rdParity |=> hrdata[DATA_W-1:PAR_W] == '0)
    else $error("parity upper bits not zero");

  irqRise_c : cover property (!extIrq ##1 extIrq);
  parityRd_c : cover property (memRdDone ##[1:8] rdParity);
  statusSvc_c : cover property (rdStatus && (|modReq));
  evtClear_c : cover property (wrEn && dphAddr_reg == ADDR_EVENT_STATUS && (|evtStatus_reg));

endmodule : hsm_regs

// ==== src/hsm_req_reduce.sv ====
// Service request of one module: any event flag with its enable set
module hsm_req_reduce #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] events,
  input  wire logic [W-1:0] enables,
  output logic              request
);

  // Follows events live; clears itself when events are cleared or disabled
  assign request = |(events & enables);

endmodule : hsm_req_reduce
